//--- rtl/rad14_driver.sv
`timescale 1ns/1ps
`default_nettype none
module rad14_driver
    import rad14_pkg::*;
#(
    parameter int WIDTH = RAD14_WIDTH
) (
    input wire logic mclk_in, // 20 MHz system clock
    input wire logic rst_n_in, // Async master reset, active low
    input wire logic clk_true_in, // Differential clock, true leg
    input wire logic clk_comp_in, // Differential clock, complement leg
    input wire logic [WIDTH-1:0] captured_inputs_in, // Address and control inputs
    input wire logic out_ready_in, // Receiver takes the presented word
    output logic [WIDTH-1:0] registered_outputs_out, // Held output word
    output logic out_valid_out, // A captured word is presented
    output logic capture_ready_out, // Buffer has room for a capture
    output logic overflow_out // Sticky: a capture found the buffer full
);
    // Structure, from pins to outputs:
    // two-flop synchronisers on data and on both clock legs,
    // an edge detector that needs both legs to switch in one sample,
    // a two-entry buffer so a stalled receiver loses no word until both entries are full,
    // and an output stage that holds its word until the next pop.
    // Pin edges cannot be stalled, so a capture into a full buffer is flagged.

    // Elaboration check: the packed carrier is fixed at the documented width
    if (WIDTH != RAD14_WIDTH) begin : g_width_check
        $error("rad14_driver: WIDTH must match the packed word");
    end

    // Positive differential transition: true leg rises, complement falls
    // Shared by the detector and by its checks, so both use one definition
    function automatic logic pos_edge(input logic t_new, input logic t_old, input logic c_new, input logic c_old);
        return t_new && !t_old && !c_new && c_old;
    endfunction

    // Pin synchronisers: data and both clock legs see the same two-flop delay
    // The third clock flop only serves the edge detector; only stage two reads stage one
    // Legs reset apart (true low, complement high), so release gives no false edge
    logic [WIDTH-1:0] data_s1_q, data_s2_q;
    logic ct_s1_q, ct_s2_q, ct_s3_q, cc_s1_q, cc_s2_q, cc_s3_q;
    logic edge_pos;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_s1_q <= RAD14_RESET_WORD;
            data_s2_q <= RAD14_RESET_WORD;
            ct_s1_q <= 1'b0;
            ct_s2_q <= 1'b0;
            ct_s3_q <= 1'b0;
            cc_s1_q <= 1'b1;
            cc_s2_q <= 1'b1;
            cc_s3_q <= 1'b1;
        end else begin
            data_s1_q <= captured_inputs_in;
            data_s2_q <= data_s1_q;
            ct_s1_q <= clk_true_in;
            ct_s2_q <= ct_s1_q;
            ct_s3_q <= ct_s2_q;
            cc_s1_q <= clk_comp_in;
            cc_s2_q <= cc_s1_q;
            cc_s3_q <= cc_s2_q;
        end
    end

    // both legs must switch
    // A single-leg glitch is not an edge; this costs nothing and rejects noise
    assign edge_pos = pos_edge(ct_s2_q, ct_s3_q, cc_s2_q, cc_s3_q);

    // Two-entry buffer between capture and output stage
    rad14_word_t mem_q [RAD14_BUF_DEPTH];
    rad14_word_t mem_d [RAD14_BUF_DEPTH];
    logic [1:0] count_q, count_d;
    logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic push, pop;
    logic [WIDTH-1:0] out_q, out_d;
    logic out_valid_q, out_valid_d, ovf_q, ovf_d;
    logic cap_ready_q, cap_ready_d;

    // Next-state for buffer, output stage and overflow flag
    // A push and a pop in one cycle leave the count unchanged
    // Ready flag is computed from the next count so the output is a flop
    always_comb begin
        mem_d = mem_q;
        count_d = count_q;
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        out_d = out_q;
        out_valid_d = out_valid_q;
        ovf_d = ovf_q;
        push = edge_pos && (count_q != 2'h2);
        pop = (count_q != 2'h0) && (!out_valid_q || out_ready_in);
        if (push) begin
            mem_d[wr_ptr_q].bits = data_s2_q;
            wr_ptr_d = ~wr_ptr_q;
        end
        // hold unless a word is moved
        if (pop) begin
            out_d = mem_q[rd_ptr_q].bits;
            out_valid_d = 1'b1;
            rd_ptr_d = ~rd_ptr_q;
        end else if (out_ready_in) begin
            out_valid_d = 1'b0; // Word taken, value itself still held
        end
        count_d = count_q + {1'b0, push} - {1'b0, pop};
        cap_ready_d = (count_d != 2'h2);
        if (edge_pos && (count_q == 2'h2)) begin
            ovf_d = 1'b1; // Pins cannot be stalled, so a lost word is flagged
        end
    end

    // all but the ready flag defined low with no clock present
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            count_q <= 2'h0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            out_q <= RAD14_RESET_WORD;
            out_valid_q <= 1'b0;
            ovf_q <= 1'b0;
            cap_ready_q <= 1'b1; // Empty buffer has room
        end else begin
            mem_q <= mem_d;
            count_q <= count_d;
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            out_q <= out_d;
            out_valid_q <= out_valid_d;
            ovf_q <= ovf_d;
            cap_ready_q <= cap_ready_d;
        end
    end

    assign registered_outputs_out = out_q;
    assign out_valid_out = out_valid_q;
    assign capture_ready_out = cap_ready_q;
    assign overflow_out = ovf_q;

    // Checks on the captured path
    // All run on the system clock; reset disables all but the reset check itself
    // Pin-level behaviour is checked after the synchronisers, where it is settled

    a_reset_outputs_low: assert property (@(posedge mclk_in) !rst_n_in |-> out_q == '0)
        else $error("outputs not low during reset");

    a_capture_on_edge: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        edge_pos && count_q == 2'h0 |=> mem_q[$past(wr_ptr_q)].bits == $past(data_s2_q))
        else $error("edge did not capture input word");

    a_fill_needs_edge: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !pos_edge(ct_s2_q, ct_s3_q, cc_s2_q, cc_s3_q) && !pop |=> count_q == $past(count_q))
        else $error("buffer filled without a clock edge");

    a_output_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        count_q == 2'h0 ##1 count_q == 2'h0 |-> $stable(out_q))
        else $error("output changed without a capture");

    a_pop_presents: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        pop |=> out_q == $past(mem_q[rd_ptr_q].bits) && out_valid_q)
        else $error("popped word not presented");

    a_after_reset_low: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $rose(rst_n_in) |-> out_q == '0 && count_q == 2'h0 && !ovf_q)
        else $error("state not cleared by reset");

    a_no_fill_no_out: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $rose(rst_n_in) ##1 !edge_pos [*3] |-> !out_valid_q)
        else $error("output valid without any capture");

    // A stalled receiver keeps both the word and its valid mark
    a_valid_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        out_valid_q && !out_ready_in |=> out_valid_q && $stable(out_q))
        else $error("presented word dropped while stalled");

    // A taken word with nothing behind it clears valid but keeps the value
    a_valid_taken: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        out_valid_q && out_ready_in && count_q == 2'h0 |=> !out_valid_q && $stable(out_q))
        else $error("taken word not retired correctly");

    // An edge into a full buffer must raise the lost-word flag
    a_ovf_on_full: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        edge_pos && count_q == 2'h2 |=> ovf_q)
        else $error("lost capture not flagged");

    // Only reset clears the lost-word flag
    a_ovf_sticky: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ovf_q |=> ovf_q)
        else $error("overflow flag cleared without reset");

    // A full buffer never grows and stays full until a pop
    a_full_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        count_q == 2'h2 && !pop |=> count_q == 2'h2)
        else $error("full buffer changed without a pop");

    // Room flag tracks the live count, one flop behind nothing
    a_ready_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        capture_ready_out == (count_q != 2'h2))
        else $error("capture ready flag out of step");

    // Two entries at most
    a_count_bound: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        count_q != 2'h3)
        else $error("buffer count beyond depth");

    // bit n of a popped word lands on output n
    for (genvar gi = 0; gi < WIDTH; gi++) begin : g_bit_map
        a_bit_maps: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
            pop |=> out_q[gi] == $past(mem_q[rd_ptr_q].bits[gi]))
            else $error("output bit not fed by its own input bit");
    end
endmodule // rad14_driver
`default_nettype wire

//--- rtl/rad14_pkg.sv
package rad14_pkg;
    localparam int RAD14_WIDTH = 14;
    localparam logic [RAD14_WIDTH-1:0] RAD14_RESET_WORD = 14'h0000;
    localparam int RAD14_BUF_DEPTH = 2;

    // One captured word with its sample of the address and control lines
    typedef struct packed {
        logic [RAD14_WIDTH-1:0] bits;
    } rad14_word_t;
endpackage

//--- sim/rad14_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module rad14_ctl_model
    import rad14_pkg::*;
(
    input wire logic mclk_in, // System clock
    output logic clk_true_out, // Clock true leg
    output logic clk_comp_out, // Clock complement leg
    output logic [RAD14_WIDTH-1:0] data_out // Address lines
);
    // Legs start apart, so no edge before the first word
    initial begin
        clk_true_out = 1'b0;
        clk_comp_out = 1'b1;
        data_out = '0;
    end
    // legs and data switch together on one system clock edge
    task automatic send(input logic [RAD14_WIDTH-1:0] w);
        @(posedge mclk_in);
        data_out <= w;
        clk_true_out <= 1'b1;
        clk_comp_out <= 1'b0;
        repeat (3) @(posedge mclk_in);
        data_out <= ~w; // Not captured: no rising edge
        clk_true_out <= 1'b0;
        clk_comp_out <= 1'b1;
        repeat (3) @(posedge mclk_in);
    endtask
endmodule // rad14_ctl_model
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rad14_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b1;
    logic out_ready_in = 1'b1;
    logic clk_true, clk_comp, valid, cap_rdy, ovf;
    logic [RAD14_WIDTH-1:0] din, q;
    int n_mismatch = 0;
    int total_checks = 0;
    // Word sent beside word expected on the outputs
    logic [RAD14_WIDTH-1:0] rows [4][2] = '{'{14'h0001, 14'h0001}, '{14'h2000, 14'h2000},
        '{14'h3fff, 14'h3fff}, '{14'h1555, 14'h1555}};
    rad14_ctl_model u_ctl (.mclk_in(mclk_in), .clk_true_out(clk_true), .clk_comp_out(clk_comp), .data_out(din));
    rad14_driver u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clk_true_in(clk_true), .clk_comp_in(clk_comp),
        .captured_inputs_in(din), .out_ready_in(out_ready_in), .registered_outputs_out(q),
        .out_valid_out(valid), .capture_ready_out(cap_rdy), .overflow_out(ovf));
    task automatic check(input logic [RAD14_WIDTH-1:0] got, input logic [RAD14_WIDTH-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Free-running system clock
    initial begin
        forever #25 mclk_in = ~mclk_in;
    end
    // Hang guard, well past the expected run length
    initial begin
        repeat (400) @(posedge mclk_in);
        n_mismatch++;
        conclude();
    end
    initial begin
        // Falling edge at time zero fires the async clear before any clock
        rst_n_in <= 1'b0;
        // Pin edge under reset must not reach the outputs
        u_ctl.send(14'h2aaa);
        check(q, RAD14_RESET_WORD);
        check({12'h000, valid, ovf}, 14'h0000);
        repeat (9) @(posedge mclk_in); // reset held until pins settle
        rst_n_in <= 1'b1;
        foreach (rows[i]) begin
            u_ctl.send(rows[i][0]);
            check(q, rows[i][1]);
        end
        check({13'h0000, cap_rdy}, 14'h0001);
        // Stalled receiver: first word holds, excess edge is flagged
        out_ready_in <= 1'b0;
        for (int k = 1; k <= 4; k++) begin
            u_ctl.send(14'(k));
        end
        check(q, 14'h0001);
        check({13'h0000, valid}, 14'h0001);
        check({13'h0000, ovf}, 14'h0001);
        check({13'h0000, cap_rdy}, 14'h0000);
        // Reset at an edge, checked before the next one
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        #1;
        check(q, RAD14_RESET_WORD);
        check({12'h000, valid, ovf}, 14'h0000);
        // Second release mid-run: buffer empty again, capture works
        @(posedge mclk_in);
        rst_n_in <= 1'b1;
        check({13'h0000, cap_rdy}, 14'h0001);
        u_ctl.send(14'h0abc);
        check(q, 14'h0abc);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
